// ### pdx_pkg.sv
// constants and carrier types for the sparse io / dense memory translator
package pdx_pkg;
    // register byte addresses on the ahb-lite bus
    localparam logic [7:0]  PDX_IO_RELOC_OFS    = 8'h00;
    localparam logic [7:0]  PDX_DENSE_RELOC_OFS = 8'h04;
    localparam logic [7:0]  PDX_STATUS_OFS      = 8'h08;
    // field widths and reset values
    localparam int          PDX_IO_RELOC_W      = 9;
    localparam int          PDX_DENSE_RELOC_W   = 2;
    localparam logic [8:0]  PDX_IO_RELOC_RST    = 9'h000;
    localparam logic [1:0]  PDX_DENSE_RELOC_RST = 2'h3;
    // address decode patterns
    localparam logic [5:0]  PDX_SPARSE_IO_PAT   = 6'h3a;
    localparam logic [3:0]  PDX_DENSE_PAT       = 4'hf;
    // burst lengths in data phases
    localparam logic [3:0]  PDX_DENSE_RD_PHASES = 4'h2;
    localparam logic [3:0]  PDX_DENSE_WR_PHASES = 4'h8;
    // pci bus commands
    localparam logic [3:0]  PDX_CMD_IO_RD       = 4'h2;
    localparam logic [3:0]  PDX_CMD_IO_WR       = 4'h3;
    localparam logic [3:0]  PDX_CMD_MEM_RD      = 4'h6;
    localparam logic [3:0]  PDX_CMD_MEM_WR      = 4'h7;
    // active-low byte enable patterns
    localparam logic [3:0]  PDX_CBE_ALL         = 4'h0;
    localparam logic [3:0]  PDX_CBE_NONE        = 4'hf;
    // cpu side request
    typedef struct packed {
        logic        write;
        logic [33:0] cpu_address;
        logic [7:0]  cpu_write_mask;
    } pdx_cpu_req_t;
    // one pci data phase handed to the pci engine
    typedef struct packed {
        logic        first;
        logic        last;
        logic [3:0]  cmd;
        logic [31:0] addr;
        logic [3:0]  cbe_n;
        logic [31:0] wdata;
    } pdx_pci_phase_t;
endpackage

// ### pdx_xlate.sv
// sparse io and dense memory translation with ahb-lite registers
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module pdx_xlate
    import pdx_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  wire logic           hsel,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hready,
    output logic                hreadyout,
    output logic [31:0]         hrdata,
    output logic                hresp,
    input  wire logic           cpu_req_valid,
    input  wire pdx_cpu_req_t   cpu_req,
    input  wire logic [255:0]   cpu_data_in,
    output logic                cpu_req_ready,
    output logic                cpu_req_hit,
    output logic                cpu_rsp_valid,
    output logic [255:0]        cpu_data_out,
    output logic                pci_phase_valid,
    output pdx_pci_phase_t      pci_phase,
    input  wire logic           pci_phase_ready,
    input  wire logic           pci_rdata_valid,
    input  wire logic [31:0]    pci_rdata
);

    typedef enum logic [3:0] {
        PDX_IDLE  = 4'b0001,
        PDX_ISSUE = 4'b0010,
        PDX_COLL  = 4'b0100,
        PDX_RESP  = 4'b1000
    } pdx_state_t;

    typedef struct packed {
        pdx_state_t     fsm;
        logic [8:0]     io_window_relocation;
        logic [1:0]     dense_window_relocation;
        logic           ahb_wr_pend;
        logic [7:0]     ahb_wr_addr;
        logic [31:0]    ahb_rdata;
        logic           is_read;
        logic           is_dense;
        logic           upper_octaword;
        logic [3:0]     nphases;
        logic [3:0]     ph_idx;
        logic [3:0]     rd_cnt;
        logic [7:0]     lw_mask;
        logic [255:0]   wbuf;
        pdx_pci_phase_t ph;
        logic           rsp;
        logic [255:0]   rsp_data;
        logic [1:0]     last_space;
    } pdx_st_t;

    pdx_st_t st_r;
    pdx_st_t st_nxt;

    // lanes for a sparse read: size+1 bytes starting at the offset
    function automatic logic [3:0] pdx_rd_lanes(input logic [1:0] ofs,
                                                input logic [1:0] sz);
        logic [7:0] run;
        run = 8'h00;
        unique case (sz)
            2'b00: run = 8'h01;
            2'b01: run = 8'h03;
            2'b10: run = 8'h07;
            2'b11: run = 8'h0f;
        endcase
        run = run << ofs;
        pdx_rd_lanes = run[3:0];
    endfunction

    // a write mask is usable only as one contiguous run in the low longword
    function automatic logic pdx_mask_ok(input logic [7:0] m);
        logic [4:0] t;
        t = 5'h00;
        t = {1'b0, m[3:0]} >> pdx_low_lane(m[3:0]);
        pdx_mask_ok = (m[7:4] == 4'h0) && (m[3:0] != 4'h0) &&
                      ((t & (t + 5'h01)) == 5'h00);
    endfunction

    // index of the lowest enabled byte lane
    function automatic logic [1:0] pdx_low_lane(input logic [3:0] m);
        pdx_low_lane = m[0] ? 2'd0 : m[1] ? 2'd1 : m[2] ? 2'd2 : 2'd3;
    endfunction

    // decode of the two windows this block owns
    logic sparse_hit;
    logic dense_hit;
    assign sparse_hit = (cpu_req.cpu_address[33:28] == PDX_SPARSE_IO_PAT);
    assign dense_hit  = (cpu_req.cpu_address[33:30] == PDX_DENSE_PAT);
    assign cpu_req_hit = sparse_hit | dense_hit;
    // only owned addresses are taken; others stay with the rest of the bridge
    assign cpu_req_ready = st_r.fsm[0] & cpu_req_hit;

    // ahb-lite slave answers in zero waits, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_r.ahb_rdata;

    assign pci_phase_valid = st_r.fsm[1];
    assign pci_phase       = st_r.ph;
    assign cpu_rsp_valid   = st_r.rsp;
    assign cpu_data_out    = st_r.rsp_data;

    // next-state logic for registers, translation and burst sequencing
    always_comb begin
        logic        ahb_take;
        logic [33:0] a;
        logic [1:0]  ofs;
        logic [3:0]  lanes;
        logic [7:0]  rpos;
        ahb_take = 1'b0;
        a        = cpu_req.cpu_address;
        ofs      = a[6:5];
        lanes    = 4'h0;
        rpos     = 8'h00;
        st_nxt   = st_r;
        st_nxt.rsp = 1'b0;

        // register write lands in the data phase after its address phase
        if (st_r.ahb_wr_pend) begin
            if (st_r.ahb_wr_addr == PDX_IO_RELOC_OFS) begin
                st_nxt.io_window_relocation = hwdata[PDX_IO_RELOC_W-1:0];
            end
            if (st_r.ahb_wr_addr == PDX_DENSE_RELOC_OFS) begin
                st_nxt.dense_window_relocation =
                    hwdata[PDX_DENSE_RELOC_W-1:0];
            end
        end
        ahb_take = hsel & hready & htrans[1];
        st_nxt.ahb_wr_pend = ahb_take & hwrite;
        st_nxt.ahb_wr_addr = haddr[7:0];
        // read data prepared at the address phase, held through data phase
        if (ahb_take & ~hwrite) begin
            unique case (haddr[7:0])
                PDX_IO_RELOC_OFS:
                    st_nxt.ahb_rdata = {23'h000000, st_r.io_window_relocation};
                PDX_DENSE_RELOC_OFS:
                    st_nxt.ahb_rdata = {30'h00000000,
                                        st_r.dense_window_relocation};
                PDX_STATUS_OFS:
                    st_nxt.ahb_rdata = {28'h0000000, st_r.last_space,
                                        1'b0, ~st_r.fsm[0]};
                default:
                    st_nxt.ahb_rdata = 32'h0000_0000;
            endcase
        end

        // read data can come back while later phases are still offered,
        // so it is taken in either busy state, longword by longword
        if (st_r.is_read && pci_rdata_valid &&
            (st_r.fsm == PDX_ISSUE || st_r.fsm == PDX_COLL)) begin
            rpos = {st_r.upper_octaword, st_r.rd_cnt[1:0], 5'b00000};
            st_nxt.rsp_data[rpos +: 32] = pci_rdata;
            st_nxt.rd_cnt = st_r.rd_cnt + 4'h1;
        end

        unique case (st_r.fsm)
            PDX_IDLE: begin
                if (cpu_req_valid & cpu_req_hit) begin
                    st_nxt.fsm       = PDX_ISSUE;
                    st_nxt.is_read   = ~cpu_req.write;
                    st_nxt.is_dense  = dense_hit;
                    st_nxt.upper_octaword = a[4];
                    st_nxt.wbuf      = cpu_data_in;
                    st_nxt.lw_mask   = cpu_req.cpu_write_mask;
                    st_nxt.ph_idx    = 4'h0;
                    st_nxt.rd_cnt    = 4'h0;
                    st_nxt.rsp_data  = '0;
                    st_nxt.last_space = dense_hit ? 2'b10 : 2'b01;
                    st_nxt.ph.first  = 1'b1;
                    st_nxt.ph.wdata  = cpu_data_in[31:0];
                    if (dense_hit) begin
                        // dense: relocation chunk on top, quadwords 1:1
                        st_nxt.ph.addr = {st_r.dense_window_relocation,
                                          a[29:5], 5'b00000};
                        if (cpu_req.write) begin
                            st_nxt.nphases = PDX_DENSE_WR_PHASES;
                            st_nxt.ph.cmd  = PDX_CMD_MEM_WR;
                            st_nxt.ph.cbe_n = cpu_req.cpu_write_mask[0] ?
                                PDX_CBE_ALL : PDX_CBE_NONE;
                        end else begin
                            st_nxt.nphases = PDX_DENSE_RD_PHASES;
                            st_nxt.ph.cmd  = PDX_CMD_MEM_RD;
                            st_nxt.ph.addr[4:3] = a[4:3];
                            st_nxt.ph.cbe_n = PDX_CBE_ALL;
                        end
                    end else begin
                        st_nxt.nphases = 4'h1;
                        // lowest 64kb is fixed at pci zero; rest relocates
                        if (a[27:21] == 7'h00) begin
                            st_nxt.ph.addr[31:16] = 16'h0000;
                        end else begin
                            st_nxt.ph.addr[31:23] =
                                st_r.io_window_relocation;
                            st_nxt.ph.addr[22:16] = a[27:21];
                        end
                        st_nxt.ph.addr[15:2] = a[20:7];
                        if (cpu_req.write) begin
                            st_nxt.ph.cmd = PDX_CMD_IO_WR;
                            if (pdx_mask_ok(cpu_req.cpu_write_mask)) begin
                                lanes = cpu_req.cpu_write_mask[3:0];
                                st_nxt.ph.addr[1:0] = pdx_low_lane(lanes);
                                st_nxt.ph.cbe_n = ~lanes;
                            end else begin
                                // odd mask: one null longword, lowest data
                                st_nxt.ph.addr[1:0] = 2'b00;
                                st_nxt.ph.cbe_n = PDX_CBE_NONE;
                            end
                        end else begin
                            st_nxt.ph.cmd = PDX_CMD_IO_RD;
                            lanes = pdx_rd_lanes(ofs, a[4:3]);
                            st_nxt.ph.addr[1:0] = ofs;
                            st_nxt.ph.cbe_n = ~lanes;
                        end
                    end
                    st_nxt.ph.last = ~dense_hit;
                end
            end
            PDX_ISSUE: begin
                // hold the phase until the pci engine accepts it
                if (pci_phase_ready) begin
                    st_nxt.ph.first = 1'b0;
                    st_nxt.ph_idx   = st_r.ph_idx + 4'h1;
                    if (st_r.ph.last) begin
                        st_nxt.fsm = st_r.is_read ? PDX_COLL : PDX_RESP;
                    end else begin
                        // dense bursts ascend one longword per phase
                        st_nxt.ph.addr = st_r.ph.addr + 32'h0000_0004;
                        st_nxt.ph.last =
                            (st_r.ph_idx + 4'h2) == st_r.nphases;
                        st_nxt.ph.wdata =
                            st_r.wbuf[32*(st_r.ph_idx[2:0]+3'd1) +: 32];
                        if (!st_r.is_read) begin
                            st_nxt.ph.cbe_n =
                                st_r.lw_mask[st_r.ph_idx[2:0]+3'd1] ?
                                PDX_CBE_ALL : PDX_CBE_NONE;
                        end
                    end
                end
            end
            PDX_COLL: begin
                // the last longword back closes the read
                if (pci_rdata_valid &&
                    (st_r.rd_cnt + 4'h1) == st_r.nphases) begin
                    st_nxt.fsm = PDX_RESP;
                end
            end
            PDX_RESP: begin
                st_nxt.rsp = 1'b1;
                st_nxt.fsm = PDX_IDLE;
            end
            default: begin
                st_nxt.fsm = PDX_IDLE;
            end
        endcase
    end

    // single state register; relocation fields come up at their defaults
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_r <= '0;
            st_r.fsm <= PDX_IDLE;
            st_r.io_window_relocation <= PDX_IO_RELOC_RST;
            st_r.dense_window_relocation <= PDX_DENSE_RELOC_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule // pdx_xlate

// ### pdx_xlate_sva.sv
// assertion checker on the translator's cpu and pci sides
`timescale 1ns/1ps
module pdx_xlate_sva
    import pdx_pkg::*;
(
    input wire logic           clk_sys,
    input wire logic           rst,
    input wire logic           cpu_req_valid,
    input wire pdx_cpu_req_t   cpu_req,
    input wire logic           cpu_req_ready,
    input wire logic           cpu_req_hit,
    input wire logic           cpu_rsp_valid,
    input wire logic           pci_phase_valid,
    input wire pdx_pci_phase_t pci_phase,
    input wire logic           pci_phase_ready
);
    pdx_cpu_req_t q_r;
    logic [3:0]   n_r;
    logic [33:0]  a;
    logic         sp, dn;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // hold the taken request and count its phases taken so far
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q_r <= '0;
            n_r <= 4'h0;
        end else if (cpu_req_valid && cpu_req_ready) begin
            q_r <= cpu_req;
            n_r <= 4'h0;
        end else if (pci_phase_valid && pci_phase_ready) begin
            n_r <= n_r + 4'h1;
        end
    end
    // space of the request in flight, only while a phase is offered
    assign a = q_r.cpu_address;
    assign sp = pci_phase_valid && a[33:28] == PDX_SPARSE_IO_PAT;
    assign dn = pci_phase_valid && a[33:30] == PDX_DENSE_PAT;
    sequence s_last_wr;
        pci_phase_valid && pci_phase_ready && pci_phase.last && q_r.write;
    endsequence
    a_hit_decode: assert property (cpu_req_hit ==
        (cpu_req.cpu_address[33:28] == PDX_SPARSE_IO_PAT
        || cpu_req.cpu_address[33:30] == PDX_DENSE_PAT)) else $error("hit");
    a_ready_hit: assert property (cpu_req_ready |-> cpu_req_hit)
        else $error("ready without hit");
    a_io_cmd: assert property (sp |-> pci_phase.first && pci_phase.last
        && pci_phase.cmd == (q_r.write ? PDX_CMD_IO_WR : PDX_CMD_IO_RD))
        else $error("io phase");
    a_io_low: assert property (sp && a[27:21] == 7'h00 |->
        pci_phase.addr[31:2] == {16'h0000, a[20:7]}) else $error("low io");
    a_io_high: assert property (sp && a[27:21] != 7'h00 |->
        pci_phase.addr[22:2] == a[27:7]) else $error("high io");
    a_dense_rd: assert property (dn && !q_r.write |->
        pci_phase.cmd == PDX_CMD_MEM_RD && pci_phase.cbe_n == PDX_CBE_ALL
        && pci_phase.addr[29:0] == {a[29:3], n_r[0], 2'b00}
        && pci_phase.last == n_r[0]) else $error("dense read");
    a_dense_wr: assert property (dn && q_r.write |->
        pci_phase.cmd == PDX_CMD_MEM_WR
        && pci_phase.addr[4:0] == {n_r[2:0], 2'b00}
        && pci_phase.cbe_n == (q_r.cpu_write_mask[n_r[2:0]] ?
        PDX_CBE_ALL : PDX_CBE_NONE) && pci_phase.last == (n_r == 4'h7))
        else $error("dense write");
    // completion passes through the response state, so it shows two
    // edges after the last phase is taken, never one
    a_wr_resp: assert property (s_last_wr |=>
        !cpu_rsp_valid ##1 cpu_rsp_valid) else $error("no write completion");
endmodule // pdx_xlate_sva

bind pdx_xlate pdx_xlate_sva u_sva (.clk_sys, .rst, .cpu_req_valid,
    .cpu_req, .cpu_req_ready, .cpu_req_hit, .cpu_rsp_valid,
    .pci_phase_valid, .pci_phase, .pci_phase_ready);

// ### pdx_pci_model.sv
// pci engine model: takes phases, answers each read a cycle later
`timescale 1ns/1ps
module pdx_pci_model
    import pdx_pkg::*;
(
    input  wire logic           clk_sys,
    input  wire logic           rst,
    input  wire logic           stall,
    input  wire logic           pci_phase_valid,
    input  wire pdx_pci_phase_t pci_phase,
    output logic                pci_phase_ready,
    output logic                pci_rdata_valid,
    output logic [31:0]         pci_rdata
);
    logic rd;
    // stall lets the bench make the engine slow or prompt
    assign pci_phase_ready = !stall;
    assign rd = pci_phase_valid && !stall && !pci_phase.cmd[0];
    // data is the inverted address; idle data toggles so stale use shows
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pci_rdata_valid <= 1'b0;
            pci_rdata <= 32'h0000_0000;
        end else begin
            pci_rdata_valid <= rd;
            pci_rdata <= rd ? ~pci_phase.addr : ~pci_rdata;
        end
    end
endmodule // pdx_pci_model

// ### testbench.sv
// self-checking bench for the sparse io and dense memory translator
`timescale 1ns/1ps
module testbench;
    import pdx_pkg::*;
    logic           clk_sys = 1'b0, rst = 1'b1, hsel = 1'b1;
    logic           hwrite = 1'b0, cpu_req_valid = 1'b0, stall = 1'b0;
    logic           hready, hreadyout, hresp, cpu_req_ready, cpu_req_hit;
    logic           cpu_rsp_valid, pci_phase_valid, pci_phase_ready;
    logic           pci_rdata_valid;
    logic [1:0]     htrans = 2'h0, d_rel = 2'h3;
    logic [2:0]     hsize = 3'h2;
    logic [8:0]     io_rel = 9'h000;
    logic [31:0]    haddr = '0, hwdata = '0, hrdata, pci_rdata;
    logic [31:0]    seed = 32'h0000_0022;
    logic [255:0]   cpu_data_in = '0, cpu_data_out;
    pdx_cpu_req_t   cpu_req = '0;
    pdx_pci_phase_t pci_phase, ph[$];
    int             bad_count = 0, comparisons = 0, cyc = 0;
    assign hready = hreadyout;
    always #5 clk_sys = ~clk_sys;
    pdx_xlate DUT (.clk_sys, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hreadyout, .hrdata, .hresp, .cpu_req_valid,
        .cpu_req, .cpu_data_in, .cpu_req_ready, .cpu_req_hit, .cpu_rsp_valid,
        .cpu_data_out, .pci_phase_valid, .pci_phase, .pci_phase_ready,
        .pci_rdata_valid, .pci_rdata);
    pdx_pci_model u_pci (.clk_sys, .rst, .stall, .pci_phase_valid,
        .pci_phase, .pci_phase_ready, .pci_rdata_valid, .pci_rdata);
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [255:0] e, g);
        comparisons++;
        if (e !== g) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // capture taken phases, stall the engine at random, bound the run
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        stall <= rnd() < 32'h4000_0000;
        if (pci_phase_valid && pci_phase_ready)
            ph.push_back(pci_phase);
        if (cyc == 30000) begin
            bad_count++;
            final_report();
        end
    end
    // one single-word transfer; read data is taken at the data edge
    task automatic ahb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        r = hrdata;
    endtask
    // expected phase k; a bad sparse write mask gives a null longword
    function automatic pdx_pci_phase_t xp(logic w, logic [33:0] a,
        logic [7:0] m, logic [255:0] d, int k);
        logic [3:0] ln;
        logic [4:0] x;
        logic [1:0] lo;
        logic       dn;
        dn = a[33:30] == PDX_DENSE_PAT;
        ln = w ? m[3:0] : 4'(8'((8'h02 << a[4:3]) - 8'h01) << a[6:5]);
        lo = ln[0] ? 2'h0 : ln[1] ? 2'h1 : ln[2] ? 2'h2 : 2'h3;
        x = {1'b0, ln >> lo};
        if (w && (m[7:4] != 4'h0 || ln == 4'h0 || ((x + 5'h01) & x) != 0))
            {ln, lo} = 6'h00;
        xp.first = k == 0;
        xp.last = k == (dn ? (w ? 7 : 1) : 0);
        xp.cmd = dn ? (w ? PDX_CMD_MEM_WR : PDX_CMD_MEM_RD)
                    : (w ? PDX_CMD_IO_WR : PDX_CMD_IO_RD);
        xp.addr = dn ? {d_rel, a[29:5], w ? 3'(k) : {a[4:3], 1'(k)}, 2'b00}
            : {a[27:21] != 7'h00 ? io_rel : 9'h000, a[27:21], a[20:7], lo};
        xp.cbe_n = dn ? (w && !m[k] ? PDX_CBE_NONE : PDX_CBE_ALL) : ~ln;
        xp.wdata = w ? d[32*(dn ? k : 0) +: 32] : 32'h0000_0000;
    endfunction
    // one cpu request, then its phases and read data against the rules
    task automatic run(input logic w, input logic [33:0] a,
                       input logic [7:0] m);
        pdx_pci_phase_t g, p0, p1;
        logic [255:0]   d, e;
        int             n;
        n = a[33:30] == PDX_DENSE_PAT ? (w ? 8 : 2) : 1;
        d = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
        ph.delete();
        cpu_data_in <= d;
        cpu_req <= '{w, a, m};
        cpu_req_valid <= 1'b1;
        do @(posedge clk_sys); while (cpu_req_ready !== 1'b1);
        cpu_req_valid <= 1'b0;
        do @(posedge clk_sys); while (cpu_rsp_valid !== 1'b1);
        chk("count", 256'(n), 256'(ph.size()));
        for (int k = 0; k < ph.size(); k++) begin
            g = ph[k];
            if (!w)
                g.wdata = '0;
            chk("phase", 256'(xp(w, a, m, d, k)), 256'(g));
        end
        p0 = xp(w, a, m, d, 0);
        p1 = xp(w, a, m, d, 1);
        // the engine returns inverted addresses; sparse reads have one
        e = {192'h0, (n == 2 ? ~p1.addr : 32'h0000_0000), ~p0.addr}
            << (a[4] ? 128 : 0);
        if (!w)
            chk("rdata", e, cpu_data_out);
    endtask
    // reset, register checks, random traffic, then an unclaimed address
    initial begin
        logic [31:0] r, y;
        logic [7:0]  m;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        ahb(1'b0, {24'h0, PDX_DENSE_RELOC_OFS}, 32'h0, r);
        chk("dense reloc", 256'(2'h3), 256'(r));
        ahb(1'b0, {24'h0, PDX_IO_RELOC_OFS}, 32'h0, r);
        chk("io reloc", 256'(0), 256'(r));
        ahb(1'b0, 32'h0000_00f0, 32'h0, r);
        chk("unmapped", 256'(0), 256'(r));
        run(1'b0, {PDX_DENSE_PAT, 30'h0000_0018}, 8'h00);
        // status: idle, last access was dense
        ahb(1'b0, {24'h0, PDX_STATUS_OFS}, 32'h0, r);
        chk("status", 256'(32'h0000_0008), 256'(r));
        for (int i = 0; i < 60; i++) begin
            y = rnd();
            if (i % 10 == 5) begin
                {io_rel, d_rel} = y[10:0];
                ahb(1'b1, {24'h0, PDX_IO_RELOC_OFS}, 32'(io_rel), r);
                ahb(1'b1, {24'h0, PDX_DENSE_RELOC_OFS}, 32'(d_rel), r);
                ahb(1'b0, {24'h0, PDX_DENSE_RELOC_OFS}, 32'h0, r);
                chk("dense reloc", 256'(d_rel), 256'(r));
            end
            r = rnd();
            // dense writes always carry at least one longword
            m = (y[3] ? y[31:24] : {4'h0, y[27:24]}) | {7'h00, y[1]};
            run(y[2], y[1] ? {PDX_DENSE_PAT, r[29:0]} : {PDX_SPARSE_IO_PAT,
                y[0] ? 7'h00 : r[27:21], r[20:0]}, m);
        end
        ph.delete();
        cpu_req <= '{1'b0, 34'h2_0000_0000, 8'h00};
        cpu_req_valid <= 1'b1;
        repeat (6) begin
            @(posedge clk_sys);
            chk("ready", 256'(0), 256'(cpu_req_ready));
            chk("hit", 256'(0), 256'(cpu_req_hit));
        end
        cpu_req_valid <= 1'b0;
        chk("stray", 256'(0), 256'(ph.size()));
        final_report();
    end
endmodule // testbench
